//--- rtl/ssa_alu.sv
// packed unsigned subtract, sum of absolute differences and byte select datapath
`timescale 1ns/10ps
module ssa_alu
   import ssa_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire ssa_req_t REQ_I,
   output ssa_res_t RES_O,
   output logic [N_BYTE-1:0] GE_O
);

   //////////////////////////////////////////////////////////////////////////
   // lane arithmetic helpers

   // halving halfword difference, borrow kept as the top bit before the shift
   function automatic logic [HALF_W-1:0] half_hsub(input logic [HALF_W-1:0] a,
                                                   input logic [HALF_W-1:0] b);
      logic [HALF_W:0] diff;
      diff = {1'b0, a} - {1'b0, b};
      return diff[HALF_W:1];
   endfunction

   // halving byte difference, borrow kept as the top bit before the shift
   function automatic logic [BYTE_W-1:0] byte_hsub(input logic [BYTE_W-1:0] a,
                                                   input logic [BYTE_W-1:0] b);
      logic [BYTE_W:0] diff;
      diff = {1'b0, a} - {1'b0, b};
      return diff[BYTE_W:1];
   endfunction

   // unsigned absolute difference of two bytes
   function automatic logic [BYTE_W-1:0] byte_absdiff(input logic [BYTE_W-1:0] a,
                                                      input logic [BYTE_W-1:0] b);
      logic [BYTE_W-1:0] d;
      d = (a >= b) ? (a - b) : (b - a);
      return d;
   endfunction

   // forbidden register index check
   function automatic logic idx_forbidden(input logic [IDX_W-1:0] idx);
      return (idx == IDX_STACK_POINTER) || (idx == IDX_PROGRAM_COUNTER);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // declarations

   logic cond_pass; // condition field holds
   logic [DATA_W-1:0] result; // combinational result of the operation
   logic [N_BYTE-1:0] ge_new; // lane compare flags from a signed halfword add
   logic [DATA_W-1:0] sad_sum; // sum of the four absolute differences
   logic [IDX_W-1:0] dest_idx; // effective destination
   logic bad_idx; // a forbidden index is named
   logic take; // instruction executes this cycle

   ssa_res_t res_q; // registered answer
   ssa_res_t res_d; // next answer
   logic [N_BYTE-1:0] ge_q; // lane compare flags
   logic [N_BYTE-1:0] ge_d; // next lane compare flags

   //////////////////////////////////////////////////////////////////////////
   // condition evaluator

   ssa_cond_eval ssa_cond_eval_i
   (
      .cond_i(REQ_I.cond),
      .nzcv_i(REQ_I.nzcv),
      .pass_o(cond_pass)
   );

   //////////////////////////////////////////////////////////////////////////
   // operand checks and destination choice
   always_comb
   begin
      // omitted destination falls back to the first source
      dest_idx = REQ_I.rd_given ? REQ_I.rd_idx : REQ_I.rn_idx;
      // a forbidden index raises illegal and blocks both write-back and the lane flag update
      bad_idx = idx_forbidden(dest_idx) || idx_forbidden(REQ_I.rn_idx)
                || idx_forbidden(REQ_I.rm_idx);
      if (REQ_I.op == OP_SUM_ABS_DIFF_ACCUMULATE)
      begin
         bad_idx = bad_idx || idx_forbidden(REQ_I.ra_idx);
      end
      if (REQ_I.op == OP_SELECT_BYTES)
      begin
         // byte select carries no index restriction
         bad_idx = 1'b0;
      end
      // skipped when the condition fails
      take = REQ_I.valid && cond_pass;
   end

   //////////////////////////////////////////////////////////////////////////
   // sum of absolute differences over the four byte lanes
   always_comb
   begin
      sad_sum = DATA_RESET;
      for (int i = 0; i < N_BYTE; i++)
      begin
         sad_sum = sad_sum + {{(DATA_W-BYTE_W){1'b0}},
                   byte_absdiff(REQ_I.rn[i*BYTE_W +: BYTE_W], REQ_I.rm[i*BYTE_W +: BYTE_W])};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // operation result and lane compare flags of a signed add
   always_comb
   begin
      logic [HALF_W-1:0] hsum;
      logic [HALF_W:0] wide;
      result = DATA_RESET;
      ge_new = ge_q;
      hsum = '0;
      wide = '0;
      case (REQ_I.op)
         OP_HALVING_SUB_HALFWORDS:
         begin
            // independent halfword lanes
            for (int h = 0; h < N_HALF; h++)
            begin
               result[h*HALF_W +: HALF_W] = half_hsub(REQ_I.rn[h*HALF_W +: HALF_W],
                                                      REQ_I.rm[h*HALF_W +: HALF_W]);
            end
         end
         OP_HALVING_SUB_BYTES:
         begin
            // independent byte lanes
            for (int i = 0; i < N_BYTE; i++)
            begin
               result[i*BYTE_W +: BYTE_W] = byte_hsub(REQ_I.rn[i*BYTE_W +: BYTE_W],
                                                      REQ_I.rm[i*BYTE_W +: BYTE_W]);
            end
         end
         OP_SUM_ABS_DIFF_BYTES:
         begin
            result = sad_sum;
         end
         OP_SUM_ABS_DIFF_ACCUMULATE:
         begin
            // wraps at the register width
            result = sad_sum + REQ_I.ra;
         end
         OP_WRAP_SUB_HALFWORDS:
         begin
            // modulo the lane width, no saturation
            for (int h = 0; h < N_HALF; h++)
            begin
               result[h*HALF_W +: HALF_W] = REQ_I.rn[h*HALF_W +: HALF_W]
                                            - REQ_I.rm[h*HALF_W +: HALF_W];
            end
         end
         OP_WRAP_SUB_BYTES:
         begin
            // modulo the lane width, no halving
            for (int i = 0; i < N_BYTE; i++)
            begin
               result[i*BYTE_W +: BYTE_W] = REQ_I.rn[i*BYTE_W +: BYTE_W]
                                            - REQ_I.rm[i*BYTE_W +: BYTE_W];
            end
         end
         OP_SELECT_BYTES:
         begin
            // every flag bit steers its own byte
            for (int i = 0; i < N_BYTE; i++)
            begin
               result[i*BYTE_W +: BYTE_W] = ge_q[i] ? REQ_I.rn[i*BYTE_W +: BYTE_W]
                                                    : REQ_I.rm[i*BYTE_W +: BYTE_W];
            end
         end
         OP_SIGNED_PACKED_HALFWORD_ADD:
         begin
            // signed sum per halfword, flags set when the lane sum is not negative
            for (int h = 0; h < N_HALF; h++)
            begin
               wide = {REQ_I.rn[h*HALF_W + HALF_W - 1], REQ_I.rn[h*HALF_W +: HALF_W]}
                      + {REQ_I.rm[h*HALF_W + HALF_W - 1], REQ_I.rm[h*HALF_W +: HALF_W]};
               hsum = wide[HALF_W-1:0];
               result[h*HALF_W +: HALF_W] = hsum;
               ge_new[2*h] = !wide[HALF_W];
               ge_new[2*h+1] = !wide[HALF_W];
            end
         end
         default:
         begin
            result = DATA_RESET;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // next answer and next lane compare flags
   always_comb
   begin
      res_d = res_q;
      ge_d = ge_q;
      res_d.valid = REQ_I.valid;
      res_d.wr_en = 1'b0;
      res_d.illegal = 1'b0;
      if (take)
      begin
         // result is held until the next taken instruction
         res_d.wr_en = !bad_idx;
         res_d.illegal = bad_idx;
         res_d.wr_idx = dest_idx;
         res_d.data = result;
         // only the signed add changes the lane flags; nothing else moves any flag
         if ((REQ_I.op == OP_SIGNED_PACKED_HALFWORD_ADD) && !bad_idx)
         begin
            ge_d = ge_new;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // registers of answer and flags
   always_ff @(posedge MCLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         res_q <= '{valid: 1'b0, wr_en: 1'b0, illegal: 1'b0, wr_idx: '0, data: DATA_RESET};
         ge_q <= GE_RESET;
      end
      else
      begin
         res_q <= res_d;
         ge_q <= ge_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs come straight from flip-flops
   assign RES_O = res_q;
   assign GE_O = ge_q;

endmodule

//--- include/ssa_pkg.sv
// package of constants, opcodes and carriers for the packed unsigned subtract alu
// Contract
// - halving halfword subtract works per 16-bit lane
// - halving halfword difference shifted right one bit
// - halving byte subtract works per byte lane
// - halving byte difference shifted, written unsigned
// - none of these ops touch status flags
// - byte select reads all lane compare flags
// - byte select takes each byte per flag
// - signed halfword add updates lane compare flags
// - sum of four byte absolute differences
// - accumulate form uses unsigned absolute differences
// - accumulate form adds third source register
// - wrap halfword subtract writes unsigned lane results
// - wrap byte subtract writes differences unhalved
// - execute only when condition field holds
// - omitted destination writes first source register
package ssa_pkg;

   localparam int DATA_W = 32; // register width
   localparam int HALF_W = 16; // halfword lane width
   localparam int BYTE_W = 8; // byte lane width
   localparam int N_HALF = 2; // halfword lanes per word
   localparam int N_BYTE = 4; // byte lanes per word
   localparam int IDX_W = 4; // register index width

   localparam logic [IDX_W-1:0] IDX_STACK_POINTER = 4'hD; // forbidden operand index
   localparam logic [IDX_W-1:0] IDX_PROGRAM_COUNTER = 4'hF; // forbidden operand index

   // positions of the condition flags in the status input
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 0;

   localparam logic [N_BYTE-1:0] GE_RESET = 4'h0; // lane compare flags after reset
   localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000; // result after reset

   // condition field encodings
   typedef enum logic [3:0] {
      COND_EQ = 4'h0,
      COND_NE = 4'h1,
      COND_CS = 4'h2,
      COND_CC = 4'h3,
      COND_MI = 4'h4,
      COND_PL = 4'h5,
      COND_VS = 4'h6,
      COND_VC = 4'h7,
      COND_HI = 4'h8,
      COND_LS = 4'h9,
      COND_GE = 4'hA,
      COND_LT = 4'hB,
      COND_GT = 4'hC,
      COND_LE = 4'hD,
      COND_AL = 4'hE,
      COND_NV = 4'hF
   } ssa_cond_t;

   // operations of the datapath
   typedef enum logic [2:0] {
      OP_HALVING_SUB_HALFWORDS = 3'h0,
      OP_HALVING_SUB_BYTES = 3'h1,
      OP_SUM_ABS_DIFF_BYTES = 3'h2,
      OP_SUM_ABS_DIFF_ACCUMULATE = 3'h3,
      OP_WRAP_SUB_HALFWORDS = 3'h4,
      OP_WRAP_SUB_BYTES = 3'h5,
      OP_SELECT_BYTES = 3'h6,
      OP_SIGNED_PACKED_HALFWORD_ADD = 3'h7
   } ssa_op_t;

   // one issued instruction from decode and register file
   typedef struct packed {
      logic valid; // instruction issued this cycle
      ssa_op_t op; // operation
      ssa_cond_t cond; // condition field
      logic [3:0] nzcv; // current condition flags
      logic rd_given; // destination named
      logic [IDX_W-1:0] rd_idx; // destination index
      logic [IDX_W-1:0] rn_idx; // first source index
      logic [IDX_W-1:0] rm_idx; // second source index
      logic [IDX_W-1:0] ra_idx; // accumulate index
      logic [DATA_W-1:0] rn; // first source value
      logic [DATA_W-1:0] rm; // second source value
      logic [DATA_W-1:0] ra; // accumulate value
   } ssa_req_t;

   // write-back answer to the register file
   typedef struct packed {
      logic valid; // answer for one issued instruction, taken or not
      logic wr_en; // write the destination
      logic illegal; // forbidden index named, write suppressed
      logic [IDX_W-1:0] wr_idx; // destination index
      logic [DATA_W-1:0] data; // result value
   } ssa_res_t;

endpackage

//--- rtl/ssa_cond_eval.sv
// condition field evaluator for the packed unsigned subtract alu
`timescale 1ns/10ps
module ssa_cond_eval
   import ssa_pkg::*;
(
   input wire ssa_cond_t cond_i,
   input wire logic [3:0] nzcv_i,
   output logic pass_o
);

   //////////////////////////////////////////////////////////////////////////
   // decode the condition against the flags
   always_comb
   begin
      pass_o = 1'b0;
      case (cond_i)
         COND_EQ: pass_o = nzcv_i[FLAG_Z];
         COND_NE: pass_o = !nzcv_i[FLAG_Z];
         COND_CS: pass_o = nzcv_i[FLAG_C];
         COND_CC: pass_o = !nzcv_i[FLAG_C];
         COND_MI: pass_o = nzcv_i[FLAG_N];
         COND_PL: pass_o = !nzcv_i[FLAG_N];
         COND_VS: pass_o = nzcv_i[FLAG_V];
         COND_VC: pass_o = !nzcv_i[FLAG_V];
         COND_HI: pass_o = nzcv_i[FLAG_C] && !nzcv_i[FLAG_Z];
         COND_LS: pass_o = !nzcv_i[FLAG_C] || nzcv_i[FLAG_Z];
         COND_GE: pass_o = nzcv_i[FLAG_N] == nzcv_i[FLAG_V];
         COND_LT: pass_o = nzcv_i[FLAG_N] != nzcv_i[FLAG_V];
         COND_GT: pass_o = !nzcv_i[FLAG_Z] && (nzcv_i[FLAG_N] == nzcv_i[FLAG_V]);
         COND_LE: pass_o = nzcv_i[FLAG_Z] || (nzcv_i[FLAG_N] != nzcv_i[FLAG_V]);
         // always and the unused code both execute
         default: pass_o = 1'b1;
      endcase
   end

endmodule

//--- tb/ssa_alu_sva.sv
// port checker of the packed subtract alu
`timescale 1ns/10ps
module ssa_alu_sva
   import ssa_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire ssa_req_t REQ_I,
   input wire ssa_res_t RES_O,
   input wire logic [N_BYTE-1:0] GE_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);
   logic [8:0] bd [N_BYTE]; // byte differences with borrow
   logic [31:0] wb, hb, sl; // expected wrap, halving and select words
   logic [16:0] s0, s1; // signed halfword sums
   logic [31:0] wh, hh, sd, sa; // expected halfword wrap, halfword halving, sum and accumulate
   logic [16:0] hd0, hd1; // halfword differences with borrow
   logic [7:0] ad; // one byte absolute difference
   logic [3:0] ga; // expected lane compare flags after a signed add
   logic ok; // unconditional issue with legal indices
   // forbidden register index
   function automatic logic bad(logic [IDX_W-1:0] x);
      return x == IDX_STACK_POINTER || x == IDX_PROGRAM_COUNTER;
   endfunction
   // expected values from the current request
   always_comb
   begin
      ok = REQ_I.valid && REQ_I.cond inside {COND_AL, COND_NV} && !bad(REQ_I.rn_idx)
         && !bad(REQ_I.rm_idx) && !bad(REQ_I.ra_idx) && !(REQ_I.rd_given && bad(REQ_I.rd_idx));
      s0 = {REQ_I.rn[15], REQ_I.rn[15:0]} + {REQ_I.rm[15], REQ_I.rm[15:0]};
      s1 = {REQ_I.rn[31], REQ_I.rn[31:16]} + {REQ_I.rm[31], REQ_I.rm[31:16]};
      hd0 = {1'b0, REQ_I.rn[15:0]} - {1'b0, REQ_I.rm[15:0]};
      hd1 = {1'b0, REQ_I.rn[31:16]} - {1'b0, REQ_I.rm[31:16]};
      wh = {hd1[15:0], hd0[15:0]};
      hh = {hd1[16:1], hd0[16:1]};
      ga = {{2{!s1[16]}}, {2{!s0[16]}}};
      sd = 32'h0000_0000;
      ad = 8'h00;
      for (int i = 0; i < N_BYTE; i++)
      begin
         bd[i] = {1'b0, REQ_I.rn[8*i+:8]} - {1'b0, REQ_I.rm[8*i+:8]};
         wb[8*i+:8] = bd[i][7:0];
         hb[8*i+:8] = bd[i][8:1];
         sl[8*i+:8] = GE_O[i] ? REQ_I.rn[8*i+:8] : REQ_I.rm[8*i+:8];
         ad = bd[i][8] ? 8'h00 - bd[i][7:0] : bd[i][7:0];
         sd = sd + {24'h00_0000, ad};
      end
      sa = sd + REQ_I.ra;
   end
   sequence s_go(ssa_op_t o);
      ok && REQ_I.op == o;
   endsequence
   sequence s_ans;
      RES_O.valid && RES_O.wr_en && !RES_O.illegal;
   endsequence
   property p_answer;
      REQ_I.valid |=> RES_O.valid;
   endproperty
   a_answer: assert property (p_answer) else $error("answer missing");
   property p_idle;
      !REQ_I.valid |=> !RES_O.valid;
   endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_cond_fail;
      REQ_I.valid && REQ_I.cond == COND_EQ && !REQ_I.nzcv[FLAG_Z]
         |=> RES_O.valid && !RES_O.wr_en && !RES_O.illegal;
   endproperty
   a_cond_fail: assert property (p_cond_fail) else $error("failed condition wrote");
   property p_wrap_bytes;
      s_go(OP_WRAP_SUB_BYTES) |=> s_ans ##0 RES_O.data == $past(wb);
   endproperty
   a_wrap_bytes: assert property (p_wrap_bytes) else $error("wrap byte result");
   property p_halving_bytes;
      s_go(OP_HALVING_SUB_BYTES) |=> s_ans ##0 RES_O.data == $past(hb);
   endproperty
   a_halving_bytes: assert property (p_halving_bytes) else $error("halving byte result");
   property p_wrap_halves;
      s_go(OP_WRAP_SUB_HALFWORDS) |=> s_ans ##0 RES_O.data == $past(wh);
   endproperty
   a_wrap_halves: assert property (p_wrap_halves) else $error("wrap halves");
   property p_halving_halves;
      s_go(OP_HALVING_SUB_HALFWORDS) |=> s_ans ##0 RES_O.data == $past(hh);
   endproperty
   a_halving_halves: assert property (p_halving_halves) else $error("halving halves");
   property p_sad;
      s_go(OP_SUM_ABS_DIFF_BYTES) |=> s_ans ##0 RES_O.data == $past(sd);
   endproperty
   a_sad: assert property (p_sad) else $error("difference sum result");
   property p_sad_acc;
      s_go(OP_SUM_ABS_DIFF_ACCUMULATE) |=> s_ans ##0 RES_O.data == $past(sa);
   endproperty
   a_sad_acc: assert property (p_sad_acc) else $error("accumulated sum result");
   property p_select;
      s_go(OP_SELECT_BYTES) |=> s_ans ##0 RES_O.data == $past(sl);
   endproperty
   a_select: assert property (p_select) else $error("select result");
   property p_flags_kept;
      REQ_I.valid && REQ_I.op != OP_SIGNED_PACKED_HALFWORD_ADD |=> $stable(GE_O);
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("flags changed");
   property p_dest;
      ok && !REQ_I.rd_given |=> s_ans ##0 RES_O.wr_idx == $past(REQ_I.rn_idx);
   endproperty
   a_dest: assert property (p_dest) else $error("default destination");
   property p_illegal;
      REQ_I.valid && REQ_I.cond == COND_AL && REQ_I.op != OP_SELECT_BYTES
         && bad(REQ_I.rm_idx) |=> RES_O.illegal && !RES_O.wr_en;
   endproperty
   a_illegal: assert property (p_illegal) else $error("forbidden index written");
   property p_ge_add;
      s_go(OP_SIGNED_PACKED_HALFWORD_ADD) |=> GE_O == $past(ga);
   endproperty
   a_ge_add: assert property (p_ge_add) else $error("compare flags after add");
endmodule
bind ssa_alu ssa_alu_sva ssa_alu_sva_i (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .REQ_I(REQ_I),
   .RES_O(RES_O), .GE_O(GE_O));

//--- tb/ssa_decode_model.sv
// decode stage and register file model feeding the alu
`timescale 1ns/10ps
module ssa_decode_model
   import ssa_pkg::*;
(
   input wire logic clk_i,
   input wire ssa_res_t res_i,
   output ssa_req_t req_o
);
   logic [DATA_W-1:0] regs [16]; // register file contents
   initial req_o = '0;
   // issue one instruction at the next rising edge
   task automatic issue(input ssa_req_t r);
      @(posedge clk_i);
      req_o <= r;
   endtask
   // drop the strobe, scramble the released fields
   task automatic idle();
      @(posedge clk_i);
      req_o <= {1'b0, ~req_o[$bits(ssa_req_t)-2:0]};
   endtask
   // write-back of executed results
   always @(posedge clk_i)
      if (res_i.valid && res_i.wr_en)
         regs[res_i.wr_idx] <= res_i.data;
endmodule

//--- tb/ssa_alu_bench.sv
// self-checking bench of the packed subtract alu
`timescale 1ns/10ps
module ssa_alu_bench
   import ssa_pkg::*;
;
   logic clk; // core clock
   logic rst_n; // active-low reset
   ssa_req_t req; // issued instruction
   ssa_res_t res; // write-back answer
   logic [N_BYTE-1:0] ge; // lane compare flags
   int error_cnt; // mismatches
   int comparisons; // checks made
   ssa_decode_model ssa_decode_model_i (.clk_i(clk), .res_i(res), .req_o(req));
   ssa_alu ssa_alu_i (.MCLK_I(clk), .NRST_I(rst_n), .REQ_I(req), .RES_O(res), .GE_O(ge));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // request with legal indices and no destination named
   function automatic ssa_req_t mk(ssa_op_t op, ssa_cond_t c, logic [31:0] a, logic [31:0] b,
      logic [31:0] x);
      mk = '0;
      mk.valid = 1'b1;
      mk.op = op;
      mk.cond = c;
      mk.rn_idx = 4'h1;
      mk.rm_idx = 4'h2;
      mk.ra_idx = 4'h3;
      mk.rn = a;
      mk.rm = b;
      mk.ra = x;
   endfunction
   // expected lane results
   function automatic logic [31:0] expect_of(ssa_op_t op, logic [31:0] a, logic [31:0] b,
      logic [31:0] c);
      logic [8:0] d;
      logic [16:0] h;
      logic [31:0] s;
      logic [7:0] m;
      s = (op == OP_SUM_ABS_DIFF_ACCUMULATE) ? c : 32'h0000_0000;
      expect_of = 32'h0000_0000;
      for (int i = 0; i < N_BYTE; i++)
      begin
         d = {1'b0, a[8*i+:8]} - {1'b0, b[8*i+:8]};
         m = d[8] ? 8'h00 - d[7:0] : d[7:0];
         s = s + {24'h00_0000, m};
         if (op == OP_HALVING_SUB_BYTES) expect_of[8*i+:8] = d[8:1];
         if (op == OP_WRAP_SUB_BYTES) expect_of[8*i+:8] = d[7:0];
      end
      for (int i = 0; i < N_HALF; i++)
      begin
         h = {1'b0, a[16*i+:16]} - {1'b0, b[16*i+:16]};
         if (op == OP_HALVING_SUB_HALFWORDS) expect_of[16*i+:16] = h[16:1];
         if (op == OP_WRAP_SUB_HALFWORDS) expect_of[16*i+:16] = h[15:0];
      end
      if (op inside {OP_SUM_ABS_DIFF_BYTES, OP_SUM_ABS_DIFF_ACCUMULATE}) expect_of = s;
   endfunction
   // one instruction and its answer
   task automatic run(input ssa_req_t r, input logic wr, input logic ill, input logic [31:0] exp);
      ssa_decode_model_i.issue(r);
      ssa_decode_model_i.idle();
      #1;
      check("valid", res.valid, 1'b1);
      check("wr_en", res.wr_en, wr);
      check("illegal", res.illegal, ill);
      if (wr)
      begin
         check("wr_idx", res.wr_idx, r.rd_given ? r.rd_idx : r.rn_idx);
         check("data", res.data, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // condition field passes and fails
   task automatic t_cond();
      ssa_req_t r;
      r = mk(OP_SIGNED_PACKED_HALFWORD_ADD, COND_EQ, 32'h0001_0001, 32'h0001_0001, 32'h0);
      run(r, 1'b0, 1'b0, 32'h0);
      check("ge", ge, 32'h0);
      r.cond = COND_NE;
      run(r, 1'b1, 1'b0, 32'h0002_0002);
      check("ge", ge, 32'hF);
      r = mk(OP_WRAP_SUB_BYTES, COND_PL, 32'h0102_0304, 32'h0202_0202, 32'h0);
      r.nzcv = 4'h8;
      run(r, 1'b0, 1'b0, 32'h0);
      r.cond = COND_MI;
      run(r, 1'b1, 1'b0, 32'hFF00_0102);
   endtask
   // every condition code against four flag patterns
   task automatic t_conds();
      ssa_req_t r;
      logic [3:0] f [4] = '{4'h6, 4'h9, 4'h2, 4'h8};
      logic [15:0] pm [4] = '{16'hE6A5, 16'hD65A, 16'hD5A6, 16'hEA9A};
      r = mk(OP_WRAP_SUB_BYTES, COND_AL, 32'h0102_0304, 32'h0202_0202, 32'h0);
      foreach (f[j])
         for (int c = 0; c < 16; c++)
         begin
            r.nzcv = f[j];
            r.cond = ssa_cond_t'(c);
            run(r, pm[j][c], 1'b0, 32'hFF00_0102);
         end
   endtask
   // select right after the add that sets the flags
   task automatic t_add_sel();
      ssa_decode_model_i.issue(mk(OP_SIGNED_PACKED_HALFWORD_ADD, COND_AL, 32'h8000_0001,
         32'h0001_FFFF, 32'h0));
      ssa_decode_model_i.issue(mk(OP_SELECT_BYTES, COND_AL, 32'hAABB_CCDD, 32'h1122_3344, 32'h0));
      #1;
      check("sum", res.data, 32'h8001_0000);
      check("ge", ge, 32'h3);
      ssa_decode_model_i.idle();
      #1;
      check("sel", res.data, 32'h1122_CCDD);
      check("ge kept", ge, 32'h3);
   endtask
   // every subtract and difference operation on borrow cases
   task automatic t_lanes();
      ssa_op_t ops [6] = '{OP_HALVING_SUB_HALFWORDS, OP_HALVING_SUB_BYTES, OP_WRAP_SUB_HALFWORDS,
         OP_WRAP_SUB_BYTES, OP_SUM_ABS_DIFF_BYTES, OP_SUM_ABS_DIFF_ACCUMULATE};
      logic [31:0] va [2] = '{32'h0102_8000, 32'hFF00_0001};
      logic [31:0] vb [2] = '{32'h0202_7FFF, 32'h00FF_0001};
      foreach (ops[k])
         foreach (va[j])
            run(mk(ops[k], COND_AL, va[j], vb[j], 32'hFFFF_FFF0), 1'b1, 1'b0,
               expect_of(ops[k], va[j], vb[j], 32'hFFFF_FFF0));
      check("ge", ge, 32'h3);
   endtask
   // forbidden index leaves the register file alone
   task automatic t_illegal();
      ssa_req_t r;
      r = mk(OP_WRAP_SUB_HALFWORDS, COND_AL, 32'h1, 32'h2, 32'h0);
      r.rm_idx = IDX_PROGRAM_COUNTER;
      run(r, 1'b0, 1'b1, 32'h0);
      @(posedge clk);
      #1;
      check("reg1", ssa_decode_model_i.regs[1], expect_of(OP_SUM_ABS_DIFF_ACCUMULATE,
         32'hFF00_0001, 32'h00FF_0001, 32'hFFFF_FFF0));
      r.rm_idx = 4'h2;
      r.rd_given = 1'b1;
      r.rd_idx = IDX_STACK_POINTER;
      run(r, 1'b0, 1'b1, 32'h0);
      r.rd_idx = 4'h4;
      run(r, 1'b1, 1'b0, 32'h0000_FFFF);
      @(posedge clk);
      #1;
      check("reg4", ssa_decode_model_i.regs[4], 32'h0000_FFFF);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog
   initial
   begin
      repeat (2000) @(posedge clk);
      error_cnt++;
      stop_test();
   end
   // main sequence
   initial
   begin
      rst_n = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_cond();
      t_conds();
      t_add_sel();
      t_lanes();
      t_illegal();
      stop_test();
   end
endmodule
